// File: hw/hctl_top.v
// heater controller: thermostat, forced tests, fault reporting, statistics, display idle logic
//
// Contract
// - test values refused while program switch disabled; not-stored notice flashes instead
// - test duration is disabled, 1 to 24 hours, or continuous
// - heater test forces heater on regardless of setpoint, unless ground-fault tripped
// - timed test expiry de-energizes forced heater and ends test
// - heater lamp lit whenever heater output is energized
// - storing disabled cancels active test at once
// - continuous setting keeps heater forced until changed to disabled
// - warning shown while any heater or alarm output is forced
// - alarm test same as heater test but drives alarm output and lamp
// - after display timeout without keys, display enters default message mode
// - measured values read-only; writes do not change them
// - each heater uses its own temperature sensor as control temperature
// - missing sensor or broken lead reports sensor-open and raises alarm
// - heater on below setpoint, stays on until temperature rises above setpoint
// - below minimum reads sensor-short, above maximum reads sensor-open
// - current in 0.1 A steps to 30.0 A, above that overload
// - ground fault above alarm threshold alarms, above trip removes heater power
// - ground-fault reading is zero while heater is off
// - statistics gathered continuously; reset clears them and records interval start
// - idle display cycles three default messages; menu keys override them
`timescale 1ns/1ps
`default_nettype none
`include "hctl_map.vh"
module hctl_top #(
  parameter CYC_PER_SEC = `HCTL_SEC_NS / `HCTL_CLK_PERIOD_NS,
  parameter SEC_PER_HOUR = `HCTL_HOUR_S
) (
  input wire hclk, // bus clock, 200 MHz
  input wire hresetn, // async reset, active low
  input wire ce, // clock enable, freezes all state when low
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size, word only
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  output wire hreadyout, // slave ready
  output wire [31:0] hrdata, // read data
  output wire hresp, // always okay
  input wire prog_enable, // program write enable switch
  input wire [23:0] temp_in, // two signed whole-degree readings, 12 bits each
  input wire [1:0] lead_open, // sensor missing or lead broken
  input wire [19:0] cur_in, // two currents in 0.1 A, 10 bits each
  input wire [21:0] gf_in, // two ground-fault currents in mA, 11 bits each
  input wire key_any, // any key pressed, one-cycle pulse
  input wire key_menu, // setpoint, measured or status key pulse
  output wire [1:0] heater_on, // heater drive
  output wire heater_lamp, // heater-active lamp
  output wire alarm_out, // alarm contact
  output wire alarm_lamp, // alarm lamp
  output wire force_warning, // some output forced on
  output wire not_stored_flash, // not-stored notice showing
  output wire disp_default, // display in default message mode
  output wire [1:0] disp_msg_sel, // default message shown, 0..2
  output wire [1:0] sensor_open_indication, // per heater sensor open
  output wire [1:0] sensor_short_indication // per heater sensor short
);
  localparam NUM_HTR = 2;
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg wr_pend_ff;
  reg [7:0] waddr_ff;
  reg [31:0] hrdata_ff;
  reg [31:0] nxt_hrdata;
  wire addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  wire acc = ce && hsel && htrans[1] && hready;
  wire wr = ce && wr_pend_ff;
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else if (ce) begin
      wr_pend_ff <= acc && hwrite && addr_ok;
      if (acc) begin
        waddr_ff <= haddr[7:0];
        hrdata_ff <= nxt_hrdata;
      end
    end
  end
  wire wr_cmd = wr && (waddr_ff == `HCTL_CMD_OFS);
  wire stat_rst = wr_cmd && hwdata[`HCTL_CMD_STRST];
  wire alm_rst = wr_cmd && hwdata[`HCTL_CMD_ALMRST];
  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  reg [31:0] cyc_ff;
  reg [31:0] uptime_ff;
  reg [31:0] stat_start_ff;
  wire sec_tick = ce && (cyc_ff == CYC_PER_SEC - 1);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_ff <= 32'h00000000;
      uptime_ff <= 32'h00000000;
      stat_start_ff <= 32'h00000000;
    end else if (ce) begin
      cyc_ff <= sec_tick ? 32'h00000000 : cyc_ff + 32'h00000001;
      if (sec_tick)
        uptime_ff <= uptime_ff + 32'h00000001;
      if (stat_rst)
        stat_start_ff <= uptime_ff;
    end
  end
  // ----------------------------------------------------------------
  // forced tests: index 0 heater, index 1 alarm
  // ----------------------------------------------------------------
  wire [1:0] t_active;
  wire [33:0] t_rem_all;
  wire [1:0] t_refused;
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_test
      reg [4:0] code_ff;
      reg [16:0] rem_ff;
      wire [7:0] ofs = (t == 0) ? `HCTL_HTEST_OFS : `HCTL_ATEST_OFS;
      wire hit = wr && (waddr_ff == ofs);
      wire legal = (hwdata[31:5] == 27'h0000000) && (hwdata[4:0] <= `HCTL_TEST_CONT);
      wire store = hit && legal && prog_enable;
      wire [31:0] load = hwdata[4:0] * SEC_PER_HOUR;
      assign t_refused[t] = hit && !prog_enable;
      // continuous runs until disabled; timed runs while seconds remain
      assign t_active[t] = (code_ff == `HCTL_TEST_CONT) || (code_ff != `HCTL_TEST_OFF);
      assign t_rem_all[t*17 +: 17] = rem_ff;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          code_ff <= `HCTL_TEST_OFF;
          rem_ff <= 17'h00000;
        end else if (ce) begin
          if (store) begin
            code_ff <= hwdata[4:0];
            rem_ff <= load[16:0];
          end else if (sec_tick && (code_ff != `HCTL_TEST_OFF) && (code_ff != `HCTL_TEST_CONT)) begin
            if (rem_ff <= 17'h00001) begin
              code_ff <= `HCTL_TEST_OFF;
              rem_ff <= 17'h00000;
            end else begin
              rem_ff <= rem_ff - 17'h00001;
            end
          end
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // not-stored notice
  // ----------------------------------------------------------------
  reg [2:0] flash_ff;
  wire cfg_hit = wr && (waddr_ff <= `HCTL_DTO_OFS) && (waddr_ff != `HCTL_HTEST_OFS) &&
                 (waddr_ff != `HCTL_ATEST_OFS);
  wire refused = (|t_refused) || (cfg_hit && !prog_enable);
  wire cfg_wr = cfg_hit && prog_enable;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      flash_ff <= 3'h0;
    else if (ce) begin
      if (refused)
        flash_ff <= `HCTL_FLASH_S; // a new refusal wins over the countdown
      else if (sec_tick && (flash_ff != 3'h0))
        flash_ff <= flash_ff - 3'h1;
    end
  end
  assign not_stored_flash = (flash_ff != 3'h0);
  // ----------------------------------------------------------------
  // shared settings
  // ----------------------------------------------------------------
  reg [10:0] gf_alm_thr_ff;
  reg [10:0] gf_trip_thr_ff;
  reg [15:0] dto_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gf_alm_thr_ff <= `HCTL_GFALM_RST;
      gf_trip_thr_ff <= `HCTL_GFTRIP_RST;
      dto_ff <= `HCTL_DTO_RST;
    end else if (cfg_wr) begin
      if (waddr_ff == `HCTL_GFALM_OFS)
        gf_alm_thr_ff <= hwdata[10:0];
      if (waddr_ff == `HCTL_GFTRIP_OFS)
        gf_trip_thr_ff <= hwdata[10:0];
      if (waddr_ff == `HCTL_DTO_OFS)
        dto_ff <= hwdata[15:0];
    end
  end
  // ----------------------------------------------------------------
  // per-heater control
  // ----------------------------------------------------------------
  wire [1:0] h_on;
  wire [1:0] h_trip;
  wire [1:0] h_open;
  wire [1:0] h_short;
  wire [1:0] h_ovl;
  wire [1:0] h_gfalm;
  wire [23:0] sp_all;
  wire [19:0] cur_all;
  wire [21:0] gf_all;
  wire [63:0] ston_all;
  genvar h;
  generate
    for (h = 0; h < NUM_HTR; h = h + 1) begin : g_htr
      reg [11:0] sp_ff;
      reg thermo_ff;
      reg trip_ff;
      reg on_ff;
      reg [9:0] cur_ff;
      reg ovl_ff;
      reg [10:0] gf_ff;
      reg [31:0] ston_ff;
      wire signed [11:0] tmp = temp_in[h*12 +: 12];
      wire signed [11:0] sp = sp_ff;
      wire signed [11:0] tmin = `HCTL_TMIN;
      wire signed [11:0] tmax = `HCTL_TMAX;
      wire [9:0] cur = cur_in[h*10 +: 10];
      wire [10:0] gf = gf_in[h*11 +: 11];
      wire [7:0] sp_ofs = (h == 0) ? `HCTL_SETPT0_OFS : `HCTL_SETPT1_OFS;
      wire is_open = lead_open[h] || (tmp > tmax);
      wire is_short = !lead_open[h] && (tmp < tmin);
      // a zero threshold stands for the setting switched off
      wire trip_now = on_ff && (gf_trip_thr_ff != 11'h000) && (gf > gf_trip_thr_ff);
      wire nxt_on = (thermo_ff || t_active[0]) && !trip_ff && !trip_now;
      assign h_on[h] = on_ff;
      assign h_trip[h] = trip_ff;
      assign h_open[h] = is_open;
      assign h_short[h] = is_short;
      assign h_ovl[h] = ovl_ff;
      assign h_gfalm[h] = (gf_alm_thr_ff != 11'h000) && (gf_ff > gf_alm_thr_ff);
      assign sp_all[h*12 +: 12] = sp_ff;
      assign cur_all[h*10 +: 10] = cur_ff;
      assign gf_all[h*11 +: 11] = gf_ff;
      assign ston_all[h*32 +: 32] = ston_ff;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sp_ff <= `HCTL_SETPT_RST;
          thermo_ff <= 1'b0;
          trip_ff <= 1'b0;
          on_ff <= 1'b0;
          cur_ff <= 10'h000;
          ovl_ff <= 1'b0;
          gf_ff <= 11'h000;
          ston_ff <= 32'h00000000;
        end else if (ce) begin
          if (cfg_wr && (waddr_ff == sp_ofs))
            sp_ff <= hwdata[11:0];
          if (is_open || is_short)
            thermo_ff <= 1'b0;
          else if (tmp < sp)
            thermo_ff <= 1'b1;
          else if (tmp > sp)
            thermo_ff <= 1'b0;
          if (trip_now)
            trip_ff <= 1'b1; // a new trip wins over the reset command
          else if (alm_rst)
            trip_ff <= 1'b0;
          on_ff <= nxt_on;
          ovl_ff <= (cur > `HCTL_CUR_MAX);
          cur_ff <= (cur > `HCTL_CUR_MAX) ? `HCTL_CUR_MAX : cur;
          gf_ff <= on_ff ? gf : 11'h000;
          if (stat_rst)
            ston_ff <= 32'h00000000;
          else if (sec_tick && on_ff)
            ston_ff <= ston_ff + 32'h00000001;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // outputs and alarm
  // ----------------------------------------------------------------
  reg alarm_ff;
  wire alarm_cond = (|h_open) || (|h_short) || (|h_gfalm) || (|h_trip);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      alarm_ff <= 1'b0;
    else if (ce)
      alarm_ff <= alarm_cond || t_active[1];
  end
  assign heater_on = h_on;
  assign heater_lamp = |h_on;
  assign alarm_out = alarm_ff;
  assign alarm_lamp = alarm_ff;
  assign force_warning = |t_active;
  assign sensor_open_indication = h_open;
  assign sensor_short_indication = h_short;
  // ----------------------------------------------------------------
  // display idle logic
  // ----------------------------------------------------------------
  localparam DS_LIVE = 2'b01;
  localparam DS_DEF = 2'b10;
  reg [1:0] dstate_ff;
  reg [1:0] nxt_dstate;
  reg [15:0] idle_ff;
  reg [1:0] msg_ff;
  reg [2:0] msg_sec_ff;
  always @* begin
    nxt_dstate = dstate_ff;
    case (dstate_ff)
      DS_LIVE: begin
        if (!key_any && !key_menu && (idle_ff >= dto_ff))
          nxt_dstate = DS_DEF;
      end
      DS_DEF: begin
        if (key_menu)
          nxt_dstate = DS_LIVE;
      end
      default: nxt_dstate = DS_LIVE;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dstate_ff <= DS_LIVE;
      idle_ff <= 16'h0000;
      msg_ff <= 2'h0;
      msg_sec_ff <= 3'h0;
    end else if (ce) begin
      dstate_ff <= nxt_dstate;
      if (key_any || key_menu)
        idle_ff <= 16'h0000;
      else if (sec_tick && (idle_ff != 16'hffff))
        idle_ff <= idle_ff + 16'h0001;
      if (dstate_ff != DS_DEF) begin
        msg_ff <= 2'h0;
        msg_sec_ff <= 3'h0;
      end else if (sec_tick) begin
        if (msg_sec_ff == `HCTL_MSG_S - 3'h1) begin
          msg_sec_ff <= 3'h0;
          msg_ff <= (msg_ff == `HCTL_NMSG - 2'h1) ? 2'h0 : msg_ff + 2'h1;
        end else begin
          msg_sec_ff <= msg_sec_ff + 3'h1;
        end
      end
    end
  end
  assign disp_default = (dstate_ff == DS_DEF);
  assign disp_msg_sel = msg_ff;
  // ----------------------------------------------------------------
  // read mux; measured registers have no write path
  // ----------------------------------------------------------------
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (addr_ok) begin
      case (haddr[7:0])
        `HCTL_SETPT0_OFS: nxt_hrdata = {20'h00000, sp_all[11:0]};
        `HCTL_SETPT1_OFS: nxt_hrdata = {20'h00000, sp_all[23:12]};
        `HCTL_GFALM_OFS: nxt_hrdata = {21'h000000, gf_alm_thr_ff};
        `HCTL_GFTRIP_OFS: nxt_hrdata = {21'h000000, gf_trip_thr_ff};
        `HCTL_HTEST_OFS: nxt_hrdata = {27'h0000000, g_test[0].code_ff};
        `HCTL_ATEST_OFS: nxt_hrdata = {27'h0000000, g_test[1].code_ff};
        `HCTL_DTO_OFS: nxt_hrdata = {16'h0000, dto_ff};
        `HCTL_STATUS_OFS: nxt_hrdata = {13'h0000, prog_enable, h_trip, h_gfalm, h_ovl, h_short, h_open,
                                        disp_msg_sel, disp_default, not_stored_flash, force_warning,
                                        alarm_ff, h_on};
        `HCTL_TEMP0_OFS: nxt_hrdata = {20'h00000, temp_in[11:0]};
        `HCTL_TEMP1_OFS: nxt_hrdata = {20'h00000, temp_in[23:12]};
        `HCTL_CUR_OFS: nxt_hrdata = {6'h00, cur_all[19:10], 6'h00, cur_all[9:0]};
        `HCTL_GF_OFS: nxt_hrdata = {5'h00, gf_all[21:11], 5'h00, gf_all[10:0]};
        `HCTL_STON0_OFS: nxt_hrdata = ston_all[31:0];
        `HCTL_STON1_OFS: nxt_hrdata = ston_all[63:32];
        `HCTL_STSTART_OFS: nxt_hrdata = stat_start_ff;
        `HCTL_UPTIME_OFS: nxt_hrdata = uptime_ff;
        `HCTL_TREM_OFS: nxt_hrdata = {t_rem_all[32:17], t_rem_all[15:0]};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/hctl_map.vh
// register offsets, field positions, reset values and timing figures of the heater controller
`ifndef HCTL_MAP_VH
`define HCTL_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HCTL_SETPT0_OFS 8'h00
`define HCTL_SETPT1_OFS 8'h04
`define HCTL_GFALM_OFS 8'h08
`define HCTL_GFTRIP_OFS 8'h0c
`define HCTL_HTEST_OFS 8'h10
`define HCTL_ATEST_OFS 8'h14
`define HCTL_DTO_OFS 8'h18
`define HCTL_CMD_OFS 8'h1c
`define HCTL_STATUS_OFS 8'h20
`define HCTL_TEMP0_OFS 8'h24
`define HCTL_TEMP1_OFS 8'h28
`define HCTL_CUR_OFS 8'h2c
`define HCTL_GF_OFS 8'h30
`define HCTL_STON0_OFS 8'h34
`define HCTL_STON1_OFS 8'h38
`define HCTL_STSTART_OFS 8'h3c
`define HCTL_UPTIME_OFS 8'h40
`define HCTL_TREM_OFS 8'h44
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HCTL_CMD_STRST 0
`define HCTL_CMD_ALMRST 1
`define HCTL_ST_HTR 0
`define HCTL_ST_ALARM 2
`define HCTL_ST_FORCE 3
`define HCTL_ST_NSTORED 4
`define HCTL_ST_DEFMODE 5
`define HCTL_ST_MSGSEL 6
`define HCTL_ST_OPEN 8
`define HCTL_ST_SHORT 10
`define HCTL_ST_OVL 12
`define HCTL_ST_GFALM 14
`define HCTL_ST_TRIP 16
`define HCTL_ST_PROGEN 18
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define HCTL_SETPT_RST 12'h032
`define HCTL_GFALM_RST 11'h014
`define HCTL_GFTRIP_RST 11'h01e
`define HCTL_DTO_RST 16'h003c
`define HCTL_TEST_OFF 5'h00
`define HCTL_TEST_MAXH 5'h18
`define HCTL_TEST_CONT 5'h19
`define HCTL_TMIN 12'hfce
`define HCTL_TMAX 12'h1f4
`define HCTL_CUR_MAX 10'h12c
`define HCTL_NMSG 2'h3
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HCTL_CLK_PERIOD_NS 5
`define HCTL_SEC_NS 1000000000
`define HCTL_HOUR_S 3600
`define HCTL_FLASH_S 3'h3
`define HCTL_MSG_S 3'h3
`endif

// File: dv/hctl_props.sv
// port-level checker for the heater controller
`timescale 1ns/1ps
`default_nettype none
module hctl_props (
  input wire hclk, // bus clock
  input wire hresetn, // async reset, active low
  input wire ce, // clock enable
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire hready, // bus ready
  input wire prog_enable, // program switch
  input wire [23:0] temp_in, // sensor readings
  input wire [1:0] lead_open, // broken sensor leads
  input wire [21:0] gf_in, // ground-fault currents
  input wire key_any, // any key pulse
  input wire key_menu, // menu key pulse
  input wire [1:0] heater_on, // heater drive
  input wire heater_lamp, // heater lamp
  input wire alarm_out, // alarm contact
  input wire not_stored_flash, // refused-store notice
  input wire force_warning, // forced output warning
  input wire disp_default, // default message mode
  input wire [1:0] disp_msg_sel, // default message index
  input wire [1:0] sensor_open_indication, // sensor open
  input wire [1:0] sensor_short_indication // sensor short
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // marks the data phase of a write into the programmable range
  logic cfg_wr_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_wr_ff <= 1'b0;
    end else begin
      cfg_wr_ff <= hsel && htrans[1] && hready && ce && hwrite && haddr <= 32'h18 && haddr[1:0] == 2'h0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_refuse; cfg_wr_ff && !prog_enable |-> ##[1:2] not_stored_flash; endproperty
  a_refuse: assert property (p_refuse) else $error("refused store shows no notice");
  property p_lamp; heater_lamp == (|heater_on); endproperty
  a_lamp: assert property (p_lamp) else $error("heater lamp differs from heater drive");
  property p_open_alarm; sensor_open_indication != 2'h0 |-> ##[1:2] alarm_out; endproperty
  a_open_alarm: assert property (p_open_alarm) else $error("open sensor raised no alarm");
  property p_lead; lead_open[1] |-> sensor_open_indication[1]; endproperty
  a_lead: assert property (p_lead) else $error("broken lead not shown as open");
  property p_short; !lead_open[0] && $signed(temp_in[11:0]) < -12'sd50 |-> sensor_short_indication[0]; endproperty
  a_short: assert property (p_short) else $error("low reading not shown as short");
  property p_high; $signed(temp_in[11:0]) > 12'sd500 |-> sensor_open_indication[0]; endproperty
  a_high: assert property (p_high) else $error("high reading not shown as open");
  property p_trip; heater_on[0] && gf_in[10:0] > 11'd30 |-> ##[1:3] !heater_on[0]; endproperty
  a_trip: assert property (p_trip) else $error("ground fault did not remove heater power");
  property p_gf_alarm; heater_on[0] && gf_in[10:0] > 11'd20 |-> ##[1:3] alarm_out; endproperty
  a_gf_alarm: assert property (p_gf_alarm) else $error("ground fault raised no alarm");
  property p_idle; $rose(disp_default) |-> !$past(key_any) && !$past(key_menu); endproperty
  a_idle: assert property (p_idle) else $error("default mode entered on a key press");
  property p_menu; key_menu |=> !disp_default; endproperty
  a_menu: assert property (p_menu) else $error("menu key left default mode on");
  property p_msg; disp_msg_sel != 2'h3; endproperty
  a_msg: assert property (p_msg) else $error("default message index out of range");
  c_forced: cover property (heater_on == 2'h3 && force_warning);
  c_default: cover property (disp_default);
  c_notice: cover property (not_stored_flash);
endmodule
`default_nettype wire

// File: dv/hctl_plant.sv
// heater circuit model: load and leakage currents flow only while a heater is driven
`timescale 1ns/1ps
`default_nettype none
module hctl_plant (
  input wire logic [1:0] heater_on, // heater drive
  input wire logic [9:0] load, // current per energized heater, 0.1 A
  input wire logic [10:0] leak, // ground leakage of heater 0, mA
  output logic [19:0] cur_in, // measured currents
  output logic [21:0] gf_in // measured ground-fault currents
);
  // a de-energized circuit carries no current, so both readings fall to zero
  assign cur_in = {heater_on[1] ? load : 10'h000, heater_on[0] ? load : 10'h000};
  assign gf_in = {11'h000, heater_on[0] ? leak : 11'h000};
endmodule
`default_nettype wire

// File: dv/heater_control_test_override_bench.sv
// self-checking bench for the heater controller
`timescale 1ns/1ps
`default_nettype none
module heater_control_test_override_bench;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, prog_enable, key_any, key_menu;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, lead_open, heater_on, disp_msg_sel, sensor_open_indication, sensor_short_indication;
  logic [2:0] hsize;
  logic [23:0] temp_in;
  logic [19:0] cur_in;
  logic [21:0] gf_in;
  logic [9:0] load;
  logic [10:0] leak;
  logic heater_lamp, alarm_out, alarm_lamp, force_warning, not_stored_flash, disp_default;
  int err_count = 0;
  int cmp_count = 0;
  assign hready = hreadyout;
  // short second and hour keep the timed tests within a few hundred cycles
  hctl_top #(.CYC_PER_SEC(10), .SEC_PER_HOUR(4)) u_hctl_top (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .prog_enable, .temp_in, .lead_open, .cur_in,
    .gf_in, .key_any, .key_menu, .heater_on, .heater_lamp, .alarm_out, .alarm_lamp, .force_warning,
    .not_stored_flash, .disp_default, .disp_msg_sel, .sensor_open_indication, .sensor_short_indication);
  hctl_plant u_hctl_plant (.heater_on, .load, .leak, .cur_in, .gf_in);
  always #2.5 hclk = ~hclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    // waits are unbounded here; only the watchdog ends a hung transfer
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp($sformatf("reg %h", a), e, r);
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_refuse;
    prog_enable <= 1'b0;
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h0);
    cmp("not_stored_flash", 1, not_stored_flash);
    prog_enable <= 1'b1;
  endtask
  task automatic t_htest;
    int n = 0;
    wr(8'h10, 32'h1); wt(2);
    cmp("heater_on", 2'h3, heater_on);
    cmp("heater_lamp", 1, heater_lamp);
    cmp("force_warning", 1, force_warning);
    wt(20); wr(8'h10, 32'h2); wt(60);
    cmp("heater_on", 2'h3, heater_on);
    while (heater_on !== 2'h0 && n < 40) begin n++; @(posedge hclk); end
    cmp("heater_on", 2'h0, heater_on);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'h19); wt(150);
    cmp("heater_on", 2'h3, heater_on);
    wr(8'h10, 32'h18); rd(8'h10, 32'h18);
    wr(8'h10, 32'h1a); rd(8'h10, 32'h18);
    wr(8'h10, 32'h0); wt(2);
    cmp("heater_on", 2'h0, heater_on);
  endtask
  task automatic t_atest;
    wr(8'h14, 32'h1); wt(2);
    cmp("alarm_out", 1, alarm_out);
    cmp("alarm_lamp", 1, alarm_lamp);
    cmp("heater_on", 2'h0, heater_on);
    cmp("force_warning", 1, force_warning);
    wr(8'h14, 32'h0); wt(2);
    cmp("alarm_out", 0, alarm_out);
  endtask
  task automatic t_thermo;
    temp_in <= {12'd60, 12'd40}; wt(3);
    cmp("heater_on", 2'h1, heater_on);
    temp_in <= {12'd60, 12'd50}; wt(3);
    cmp("heater_on", 2'h1, heater_on);
    temp_in <= {12'd40, 12'd51}; wt(3);
    cmp("heater_on", 2'h2, heater_on);
    temp_in <= {12'd100, 12'd100}; wt(3);
    rd(8'h24, 32'h64); wr(8'h24, 32'hffff); rd(8'h24, 32'h64);
  endtask
  task automatic t_sensor;
    lead_open <= 2'h2; wt(3);
    cmp("sensor_open", 2'h2, sensor_open_indication);
    cmp("alarm_out", 1, alarm_out);
    lead_open <= 2'h0; temp_in <= {12'd100, 12'hfcd}; wt(1);
    cmp("sensor_short", 2'h1, sensor_short_indication);
    temp_in <= {12'h1f5, 12'd100}; wt(1);
    cmp("sensor_open", 2'h2, sensor_open_indication);
    temp_in <= {12'd100, 12'd100}; wt(1);
  endtask
  task automatic t_ground;
    temp_in <= {12'd100, 12'd40}; load <= 10'd333; leak <= 11'd25; wt(5);
    cmp("alarm_out", 1, alarm_out);
    rd(8'h2c, 32'h12c);
    leak <= 11'd40; wt(4);
    cmp("heater_on", 2'h0, heater_on);
    rd(8'h30, 32'h0);
    leak <= 11'd0; load <= 10'd55; wr(8'h1c, 32'h2); wt(3);
    cmp("heater_on", 2'h1, heater_on);
    rd(8'h2c, 32'h37);
    temp_in <= {12'd100, 12'd100}; wt(3);
    wr(8'h1c, 32'h1); wt(2);
    rd(8'h34, 32'h0);
  endtask
  task automatic t_display;
    int n = 0;
    wr(8'h18, 32'h2);
    key_menu <= 1'b1; @(posedge hclk); key_menu <= 1'b0; wt(10);
    cmp("disp_default", 0, disp_default);
    while (disp_default !== 1'b1 && n < 40) begin n++; @(posedge hclk); end
    cmp("disp_default", 1, disp_default);
    wt(40);
    cmp("disp_msg_sel", 1, disp_msg_sel);
    key_any <= 1'b1; @(posedge hclk); key_any <= 1'b0; wt(2);
    cmp("disp_default", 1, disp_default);
    key_menu <= 1'b1; @(posedge hclk); key_menu <= 1'b0; wt(2);
    cmp("disp_default", 0, disp_default);
  endtask
  initial begin
    hclk = 1'b0; hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; prog_enable = 1'b1; temp_in = {12'd100, 12'd100}; lead_open = 2'h0;
    key_any = 1'b0; key_menu = 1'b0; load = 10'h000; leak = 11'h000;
    wt(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h14); rd(8'h0c, 32'h1e); rd(8'h18, 32'h3c); rd(8'h48, 32'h0);
    t_refuse();
    t_htest();
    t_atest();
    t_thermo();
    t_sensor();
    t_ground();
    t_display();
    final_report();
  end
  initial begin
    #25000;
    err_count++;
    final_report();
  end
endmodule
bind hctl_top hctl_props u_hctl_props (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .prog_enable,
  .temp_in, .lead_open, .gf_in, .key_any, .key_menu, .heater_on, .heater_lamp, .alarm_out, .not_stored_flash,
  .force_warning, .disp_default, .disp_msg_sel, .sensor_open_indication, .sensor_short_indication);
`default_nettype wire
